// file: rtl/tapsc_pkg.sv
// Contract
// [R1] clock, mode, data in, compliance in; data out, ready
// [R2] sample on tck rise, tdo moves on fall
// [R3] sixteen-state machine steered by sampled tms
// [R4] five tms-high rises always reach test-logic-reset
// [R5] controller held reset while in test-logic-reset
// [R6] power-on or compliance low forces reset immediately
// [R7] without compliance pin: always enabled, tms reset
// [R8] after reset controller owns pins, no client
// [R9] client chosen only by opcode while compliance high
// [R10] opcodes 10000 to 10100 pick the five clients
// [R11] chosen client gets tdi/tms and drives tdo
// [R12] update-dr after pause-dr returns pins to controller
// [R13] unselected clients kept in run-test/idle
// [R14] instruction shifted lsb first, last with tms high
// [R15] standard graph, capture/update timing, bypass otherwise
package tapsc_pkg;

  localparam int        IR_W   = 5;
  localparam int        N_AUX  = 5;
  // client-select opcodes
  localparam logic [4:0] OP_PORT_CTRL  = 5'h10; // select_port_ctrl_tap
  localparam logic [4:0] OP_CORE_DBG   = 5'h11; // select_core_debug_tap
  localparam logic [4:0] OP_TIMING     = 5'h12; // select_timing_unit_tap
  localparam logic [4:0] OP_DMA_DBG    = 5'h13; // select_dma_debug_tap
  localparam logic [4:0] OP_AUTOBUS    = 5'h14; // select_autobus_debug_tap
  // instruction register values
  localparam logic [4:0] IR_CAPTURE    = 5'h01; // fixed 01 pattern on capture
  localparam logic [4:0] IR_RESET      = 5'h1F; // bypass after reset
  localparam logic [4:0] SEL_NONE      = 5'h00; // no client owns the pins
  localparam logic [2:0] TMS_RESET_CNT = 3'h5;  // rises to force reset

  // tap controller states
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
    ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tapsc_state_t;

  // pins sampled together through the synchroniser
  typedef struct packed {
    logic comp;
    logic tck;
    logic tms;
    logic tdi;
  } tapsc_pins_t;

endpackage : tapsc_pkg

// file: rtl/tapsc_top.sv
`timescale 1ns/1ps
module tapsc_top #(
  parameter bit HAS_COMP = 1'b1 // compliance pin present
) (
  input  wire logic       clk_sys,      // 40 MHz system clock
  input  wire logic       reset,        // power-on reset, sync high
  input  wire logic       clk_en,       // low freezes all state
  input  wire logic       tck_pin,      // test clock pin
  input  wire logic       tms_pin,      // test mode select pin
  input  wire logic       tdi_pin,      // test data in pin
  input  wire logic       comp_en_pin,  // compliance_enable pin
  output logic            tdo_pin,      // test data out
  output logic            tdo_oe_n,     // low while tdo is driven
  output logic            dbg_ready,    // high when out of reset
  output logic            ctrl_reset,   // controller held in reset
  output logic [4:0]      aux_sel,      // one-hot client owning pins
  output logic [4:0]      aux_tms,      // tms per client
  output logic            aux_tdi,      // tdi to clients
  output logic            aux_tck_rise, // one-cycle tck rise pulse
  output logic            aux_tck_fall, // one-cycle tck fall pulse
  input  wire logic [4:0] aux_tdo       // client serial outputs
);

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  tapsc_pkg::tapsc_pins_t meta_ff, sync_ff, nxt_meta, nxt_sync;
  logic                   tck_d_ff, nxt_tck_d;

  // tck is sampled like data; edges come from its stage-two copy and that copy delayed once more
  always_comb begin
    nxt_meta  = {comp_en_pin, tck_pin, tms_pin, tdi_pin};
    nxt_sync  = meta_ff;
    nxt_tck_d = sync_ff.tck;
  end

  // reset state has compliance low so no client can sneak in
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_ff  <= '0;
      sync_ff  <= '0;
      tck_d_ff <= 1'b0;
    end else if (clk_en) begin
      meta_ff  <= nxt_meta;
      sync_ff  <= nxt_sync;
      tck_d_ff <= nxt_tck_d;
    end
  end

  logic rise, fall, comp_off, own;
  assign rise     = sync_ff.tck & ~tck_d_ff;   // [R2]
  assign fall     = ~sync_ff.tck & tck_d_ff;   // [R2]
  assign comp_off = HAS_COMP & ~sync_ff.comp;  // [R7]

  // ----------------------------------------------------------------
  // tap state graph
  // ----------------------------------------------------------------
  function automatic tapsc_pkg::tapsc_state_t tap_next(
    input tapsc_pkg::tapsc_state_t s,
    input logic                    tms
  );
    tapsc_pkg::tapsc_state_t n;
    n = s;
    unique case (s)
      tapsc_pkg::ST_TLR:      n = tms ? tapsc_pkg::ST_TLR
                                      : tapsc_pkg::ST_RTI;
      tapsc_pkg::ST_RTI:      n = tms ? tapsc_pkg::ST_SEL_DR
                                      : tapsc_pkg::ST_RTI;
      tapsc_pkg::ST_SEL_DR:   n = tms ? tapsc_pkg::ST_SEL_IR
                                      : tapsc_pkg::ST_CAP_DR;
      tapsc_pkg::ST_CAP_DR:   n = tms ? tapsc_pkg::ST_EXIT1_DR
                                      : tapsc_pkg::ST_SHIFT_DR;
      tapsc_pkg::ST_SHIFT_DR: n = tms ? tapsc_pkg::ST_EXIT1_DR
                                      : tapsc_pkg::ST_SHIFT_DR;
      tapsc_pkg::ST_EXIT1_DR: n = tms ? tapsc_pkg::ST_UPD_DR
                                      : tapsc_pkg::ST_PAUSE_DR;
      tapsc_pkg::ST_PAUSE_DR: n = tms ? tapsc_pkg::ST_EXIT2_DR
                                      : tapsc_pkg::ST_PAUSE_DR;
      tapsc_pkg::ST_EXIT2_DR: n = tms ? tapsc_pkg::ST_UPD_DR
                                      : tapsc_pkg::ST_SHIFT_DR;
      tapsc_pkg::ST_UPD_DR:   n = tms ? tapsc_pkg::ST_SEL_DR
                                      : tapsc_pkg::ST_RTI;
      tapsc_pkg::ST_SEL_IR:   n = tms ? tapsc_pkg::ST_TLR
                                      : tapsc_pkg::ST_CAP_IR;
      tapsc_pkg::ST_CAP_IR:   n = tms ? tapsc_pkg::ST_EXIT1_IR
                                      : tapsc_pkg::ST_SHIFT_IR;
      tapsc_pkg::ST_SHIFT_IR: n = tms ? tapsc_pkg::ST_EXIT1_IR
                                      : tapsc_pkg::ST_SHIFT_IR;
      tapsc_pkg::ST_EXIT1_IR: n = tms ? tapsc_pkg::ST_UPD_IR
                                      : tapsc_pkg::ST_PAUSE_IR;
      tapsc_pkg::ST_PAUSE_IR: n = tms ? tapsc_pkg::ST_EXIT2_IR
                                      : tapsc_pkg::ST_PAUSE_IR;
      tapsc_pkg::ST_EXIT2_IR: n = tms ? tapsc_pkg::ST_UPD_IR
                                      : tapsc_pkg::ST_SHIFT_IR;
      tapsc_pkg::ST_UPD_IR:   n = tms ? tapsc_pkg::ST_SEL_DR
                                      : tapsc_pkg::ST_RTI;
    endcase
    return n;
  endfunction : tap_next

  // opcode to one-hot client; anything else leaves bypass in charge
  function automatic logic [4:0] client_of(input logic [4:0] op);
    logic [4:0] s;
    s = tapsc_pkg::SEL_NONE;
    case (op)
      tapsc_pkg::OP_PORT_CTRL: s = 5'h01;
      tapsc_pkg::OP_CORE_DBG:  s = 5'h02;
      tapsc_pkg::OP_TIMING:    s = 5'h04;
      tapsc_pkg::OP_DMA_DBG:   s = 5'h08;
      tapsc_pkg::OP_AUTOBUS:   s = 5'h10;
      default:                 s = tapsc_pkg::SEL_NONE;
    endcase
    return s;
  endfunction : client_of

  // ----------------------------------------------------------------
  // controller state
  // ----------------------------------------------------------------
  tapsc_pkg::tapsc_state_t state_ff, nxt_state;
  logic [4:0] ir_sr_ff, nxt_ir_sr;  // instruction shift stage
  logic [4:0] ir_ff, nxt_ir;        // current instruction
  logic [4:0] sel_ff, nxt_sel;      // client owning the pins
  logic       byp_ff, nxt_byp;      // one-bit bypass register
  logic       pause_ff, nxt_pause;  // pause-dr seen in this scan
  logic       tdo_ff, nxt_tdo;
  logic       oe_n_ff, nxt_oe_n;
  logic [4:0] atms_ff, nxt_atms;
  logic       atdi_ff, arise_ff, afall_ff, rst_ff, rdy_ff;
  logic       nxt_atdi, nxt_arise, nxt_afall, nxt_rst, nxt_rdy;

  assign own = (sel_ff == tapsc_pkg::SEL_NONE);

  always_comb begin
    nxt_state = state_ff;
    nxt_ir_sr = ir_sr_ff;
    nxt_ir    = ir_ff;
    nxt_sel   = sel_ff;
    nxt_byp   = byp_ff;
    nxt_pause = pause_ff;
    nxt_tdo   = tdo_ff;
    nxt_oe_n  = oe_n_ff;
    // the graph keeps running under a client so the way back is seen
    if (rise) begin
      nxt_state = tap_next(state_ff, sync_ff.tms);          // [R3] [R4]
      unique case (state_ff)
        tapsc_pkg::ST_CAP_IR: if (own) begin
          nxt_ir_sr = tapsc_pkg::IR_CAPTURE;                 // [R15]
        end
        tapsc_pkg::ST_SHIFT_IR: if (own) begin
          nxt_ir_sr = {sync_ff.tdi, ir_sr_ff[4:1]};          // [R14]
        end
        tapsc_pkg::ST_CAP_DR: begin
          nxt_byp   = 1'b0;                                  // [R15]
          nxt_pause = 1'b0;
        end
        tapsc_pkg::ST_SHIFT_DR: nxt_byp = sync_ff.tdi;
        default: ;
      endcase
    end
    if (state_ff == tapsc_pkg::ST_PAUSE_DR) begin
      nxt_pause = 1'b1;
    end
    // updates on the falling edge, as the standard has it
    if (fall) begin
      if (own && state_ff == tapsc_pkg::ST_UPD_IR) begin
        nxt_ir  = ir_sr_ff;                                  // [R15]
        nxt_sel = client_of(ir_sr_ff);                       // [R9] [R10]
      end
      if (!own && state_ff == tapsc_pkg::ST_UPD_DR && pause_ff) begin
        nxt_sel = tapsc_pkg::SEL_NONE;                       // [R12]
        nxt_ir  = tapsc_pkg::IR_RESET;
      end
      if (own) begin
        nxt_tdo  = (state_ff == tapsc_pkg::ST_SHIFT_IR) ? ir_sr_ff[0]
                                                        : byp_ff;
        nxt_oe_n = !(state_ff == tapsc_pkg::ST_SHIFT_IR ||
                     state_ff == tapsc_pkg::ST_SHIFT_DR);
      end else begin
        nxt_tdo  = |(aux_tdo & sel_ff);                      // [R11]
        nxt_oe_n = 1'b0;
      end
    end
    if (state_ff == tapsc_pkg::ST_TLR) begin
      nxt_ir  = tapsc_pkg::IR_RESET;                         // [R5]
      nxt_sel = tapsc_pkg::SEL_NONE;                         // [R8]
    end
    // no tck edge needed: compliance low wins over state, instruction, selection and output enable
    if (comp_off) begin
      nxt_state = tapsc_pkg::ST_TLR;                         // [R6]
      nxt_ir    = tapsc_pkg::IR_RESET;
      nxt_sel   = tapsc_pkg::SEL_NONE;                       // [R8] [R9]
      nxt_oe_n  = 1'b1;
    end
    // idle clients see tms low and so stay in run-test/idle
    nxt_atms = nxt_sel & {5{sync_ff.tms}};                   // [R11] [R13]
    // pass-through copies, registered with the rest to stay aligned
    nxt_atdi  = sync_ff.tdi;
    nxt_arise = rise;
    nxt_afall = fall;
    nxt_rst   = (nxt_state == tapsc_pkg::ST_TLR);           // [R5]
    nxt_rdy   = (nxt_state != tapsc_pkg::ST_TLR);           // [R1]
  end

  // all outputs are registered together so clients see them aligned
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_ff <= tapsc_pkg::ST_TLR;                         // [R6]
      ir_sr_ff <= tapsc_pkg::IR_RESET;
      ir_ff    <= tapsc_pkg::IR_RESET;
      sel_ff   <= tapsc_pkg::SEL_NONE;                       // [R8]
      byp_ff   <= 1'b0;
      pause_ff <= 1'b0;
      tdo_ff   <= 1'b0;
      oe_n_ff  <= 1'b1;
      atms_ff  <= 5'h00;
      atdi_ff  <= 1'b0;
      arise_ff <= 1'b0;
      afall_ff <= 1'b0;
      rst_ff   <= 1'b1;
      rdy_ff   <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      ir_sr_ff <= nxt_ir_sr;
      ir_ff    <= nxt_ir;
      sel_ff   <= nxt_sel;
      byp_ff   <= nxt_byp;
      pause_ff <= nxt_pause;
      tdo_ff   <= nxt_tdo;
      oe_n_ff  <= nxt_oe_n;
      atms_ff  <= nxt_atms;
      atdi_ff  <= nxt_atdi;
      arise_ff <= nxt_arise;
      afall_ff <= nxt_afall;
      rst_ff   <= nxt_rst;                                   // [R5]
      rdy_ff   <= nxt_rdy;                                   // [R1]
    end
  end

  assign tdo_pin      = tdo_ff;                              // [R1]
  assign tdo_oe_n     = oe_n_ff;
  assign dbg_ready    = rdy_ff;
  assign ctrl_reset   = rst_ff;
  assign aux_sel      = sel_ff;
  assign aux_tms      = atms_ff;
  assign aux_tdi      = atdi_ff;
  assign aux_tck_rise = arise_ff;
  assign aux_tck_fall = afall_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [2:0] hi_cnt_ff; // consecutive tms-high rises, saturating
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hi_cnt_ff <= 3'h0;
    end else if (clk_en && rise) begin
      hi_cnt_ff <= !sync_ff.tms ? 3'h0
                 : (hi_cnt_ff == tapsc_pkg::TMS_RESET_CNT) ? hi_cnt_ff
                 : hi_cnt_ff + 3'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_core_load;
    clk_en && fall && own && !comp_off && state_ff == tapsc_pkg::ST_UPD_IR
      && ir_sr_ff == tapsc_pkg::OP_CORE_DBG;
  endsequence
  sequence s_release;
    clk_en && fall && !own && !comp_off
      && state_ff == tapsc_pkg::ST_UPD_DR && pause_ff;
  endsequence

  five_high_a: assert property ( // [R4]
    hi_cnt_ff == tapsc_pkg::TMS_RESET_CNT |-> state_ff == tapsc_pkg::ST_TLR)
    else $error("five tms-high rises did not reach reset");
  held_reset_a: assert property ( // [R5]
    ctrl_reset == (state_ff == tapsc_pkg::ST_TLR))
    else $error("controller reset does not follow state");
  comp_off_a: assert property ( // [R6]
    clk_en && comp_off |=> state_ff == tapsc_pkg::ST_TLR
                           && aux_sel == tapsc_pkg::SEL_NONE)
    else $error("compliance low did not force reset");
  core_select_a: assert property ( // [R10]
    s_core_load |=> aux_sel == 5'h02 ##1 aux_tms == (5'h02 & {5{$past(
      sync_ff.tms)}}))
    else $error("core opcode did not select core client");
  pause_release_a: assert property ( // [R12]
    s_release |=> own && aux_sel == tapsc_pkg::SEL_NONE)
    else $error("pins not returned after pause and update");
  idle_hold_a: assert property ( // [R13]
    (aux_tms & ~aux_sel) == 5'h00)
    else $error("unselected client saw tms high");
  tdo_on_fall_a: assert property ( // [R2]
    $changed(tdo_pin) |-> $past(fall && clk_en))
    else $error("tdo moved outside a tck fall");
  ir_shift_a: assert property ( // [R14]
    clk_en && rise && own && state_ff == tapsc_pkg::ST_SHIFT_IR
      |=> ir_sr_ff[4] == $past(sync_ff.tdi))
    else $error("instruction bit not shifted in at msb");
  state_on_rise_a: assert property ( // [R3]
    $changed(state_ff) |-> $past(rise || comp_off))
    else $error("state moved without a tck rise");

endmodule : tapsc_top

// file: tb/tapsc_probe.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// debug probe model: drives the serial test pins, reads data out
// ------------------------------------------------------------------
module tapsc_probe (
  input  wire logic clk_sys, // bench system clock
  output logic      tck,     // test clock to the pin
  output logic      tms,     // mode select to the pin
  output logic      tdi,     // data in to the pin
  input  wire logic tdo      // data out from the pin
);

  // test clock stands low between frames, it never runs free
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end

  // one test clock period of 8 system cycles, called just after an edge;
  // mode and data move only with the fall, so they are settled at the
  // rise and the read of data out at the end sees the value set on the
  // fall
  task automatic bit_step(input logic m, input logic d, output logic q);
    tck <= 1'h0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk_sys);
    tck <= 1'h1;
    repeat (4) @(posedge clk_sys);
    q = tdo;
  endtask : bit_step

  // drop the test clock and leave it still for one period
  task automatic idle();
    tck <= 1'h0;
    repeat (8) @(posedge clk_sys);
  endtask : idle

  // instruction scan from run-test/idle: lsb first, last bit with mode
  // high, then back to idle; returns what the device shifted out
  task automatic ir_load(input logic [4:0] op, output logic [4:0] cap);
    logic t;
    bit_step(1'h1, 1'h0, t);
    bit_step(1'h1, 1'h0, t);
    bit_step(1'h0, 1'h0, t);
    bit_step(1'h0, 1'h0, t);
    for (int k = 0; k < 5; k++) begin
      bit_step(k == 4, op[k], cap[k]);
    end
    bit_step(1'h1, 1'h0, t);
    bit_step(1'h0, 1'h0, t);
    idle();
  endtask : ir_load

  // data scan from select-dr back to idle, through pause-dr if asked;
  // the pause path is how the probe hands the pins back
  task automatic dr_scan(input logic pause);
    logic t;
    bit_step(1'h0, 1'h0, t);
    bit_step(1'h0, 1'h0, t);
    bit_step(1'h1, 1'h0, t);
    if (pause) begin
      bit_step(1'h0, 1'h0, t);
      bit_step(1'h1, 1'h0, t);
    end
    bit_step(1'h1, 1'h0, t);
    bit_step(1'h0, 1'h0, t);
    idle();
  endtask : dr_scan

endmodule : tapsc_probe

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic       clk_sys;
  logic       reset;
  logic       comp_en_pin;
  logic       tck_pin;
  logic       tms_pin;
  logic       tdi_pin;
  logic       tdo_pin;
  logic       tdo_oe_n;
  logic       dbg_ready;
  logic       ctrl_reset;
  logic       aux_tdi;
  logic       t;
  logic [4:0] aux_sel;
  logic [4:0] aux_tms;
  logic [4:0] aux_tdo;
  logic [4:0] cap;
  logic [4:0] aux_sel_nc;
  logic       ctrl_reset_nc;
  logic       aux_tck_rise;
  logic       aux_tck_fall;
  logic       tdo_line;
  int         failures;
  int         n_tests;
  int         n_rise = 0;
  int         n_fall = 0;
  int         r0;
  int         f0;

  // ------------------------------------------------------------------
  // design, probe and clock
  // ------------------------------------------------------------------
  tapsc_top dut (.clk_sys(clk_sys), .reset(reset), .clk_en(1'h1),
    .tck_pin(tck_pin), .tms_pin(tms_pin), .tdi_pin(tdi_pin),
    .comp_en_pin(comp_en_pin), .tdo_pin(tdo_pin), .tdo_oe_n(tdo_oe_n),
    .dbg_ready(dbg_ready), .ctrl_reset(ctrl_reset), .aux_sel(aux_sel),
    .aux_tms(aux_tms), .aux_tdi(aux_tdi), .aux_tck_rise(aux_tck_rise),
    .aux_tck_fall(aux_tck_fall), .aux_tdo(aux_tdo));

  // copy without the compliance pin: only the mode pin can reset it
  tapsc_top #(.HAS_COMP(1'b0)) dut_nc (.clk_sys(clk_sys), .reset(reset),
    .clk_en(1'h1), .tck_pin(tck_pin), .tms_pin(tms_pin),
    .tdi_pin(tdi_pin), .comp_en_pin(comp_en_pin), .tdo_pin(),
    .tdo_oe_n(), .dbg_ready(), .ctrl_reset(ctrl_reset_nc),
    .aux_sel(aux_sel_nc), .aux_tms(), .aux_tdi(), .aux_tck_rise(),
    .aux_tck_fall(), .aux_tdo(aux_tdo));

  // an undriven data-out line reads as the inverse, so a read while
  // the design has let go of the pin cannot pass by luck
  assign tdo_line = tdo_oe_n ? ~tdo_pin : tdo_pin;

  tapsc_probe probe (.clk_sys(clk_sys), .tck(tck_pin), .tms(tms_pin),
    .tdi(tdi_pin), .tdo(tdo_line));

  // count the one-cycle clock pulses handed on to the clients
  always @(posedge clk_sys) begin
    if (aux_tck_rise === 1'h1) begin
      n_rise <= n_rise + 1;
    end
    if (aux_tck_fall === 1'h1) begin
      n_fall <= n_fall + 1;
    end
  end

  // 40 MHz system clock
  initial clk_sys = 1'h0;
  always #12.5 clk_sys = ~clk_sys;

  // ------------------------------------------------------------------
  // compare and verdict
  // ------------------------------------------------------------------
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  // after power-on the controller sits in reset and owns the pins
  task automatic t_reset();
    chk(ctrl_reset, 5'h01);
    chk(dbg_ready, 5'h00);
    chk(aux_sel, 5'h00);
    chk(tdo_oe_n, 5'h01);
    probe.bit_step(1'h0, 1'h0, t);
    probe.idle();
    chk(ctrl_reset, 5'h00);
  endtask : t_reset

  // every client code: select, route, keep selection on a plain data
  // scan, then hand back through pause-dr
  task automatic t_select();
    logic [4:0] ops [5];
    ops = '{tapsc_pkg::OP_PORT_CTRL, tapsc_pkg::OP_CORE_DBG,
      tapsc_pkg::OP_TIMING, tapsc_pkg::OP_DMA_DBG, tapsc_pkg::OP_AUTOBUS};
    for (int i = 0; i < 5; i++) begin
      // client output set first: data out follows it from the first fall after the select
      aux_tdo <= 5'h01 << i;
      probe.ir_load(ops[i], cap);
      chk(cap, tapsc_pkg::IR_CAPTURE);
      chk(aux_sel, 5'h01 << i);
      r0 = n_rise;
      f0 = n_fall;
      probe.bit_step(1'h1, 1'h1, t);
      chk(t, 5'h01);
      chk(aux_tdi, 5'h01);
      chk(aux_tms, 5'h01 << i);
      chk(tdo_oe_n, 5'h00);
      aux_tdo <= ~(5'h01 << i);
      probe.dr_scan(1'h0);
      chk(aux_sel, 5'h01 << i);
      chk(5'(n_rise - r0), 5'h06);
      chk(5'(n_fall - f0), 5'h06);
      probe.bit_step(1'h1, 1'h0, t);
      chk(t, 5'h00);
      chk(aux_tdi, 5'h00);
      probe.dr_scan(1'h1);
      chk(aux_sel, 5'h00);
      chk(aux_tms, 5'h00);
    end
  endtask : t_select

  // five mode-high clocks from inside an instruction shift reset it all
  task automatic t_tms_reset();
    probe.bit_step(1'h1, 1'h0, t);
    probe.bit_step(1'h1, 1'h0, t);
    probe.bit_step(1'h0, 1'h0, t);
    probe.bit_step(1'h0, 1'h0, t);
    repeat (5) probe.bit_step(1'h1, 1'h0, t);
    probe.idle();
    chk(ctrl_reset, 5'h01);
    chk(ctrl_reset_nc, 5'h01);
    chk(dbg_ready, 5'h00);
    probe.bit_step(1'h0, 1'h0, t);
    probe.idle();
    chk(dbg_ready, 5'h01);
  endtask : t_tms_reset

  // compliance low drops a client with the test clock standing still,
  // and the core code cannot select while it stays low
  task automatic t_comp();
    probe.ir_load(tapsc_pkg::OP_CORE_DBG, cap);
    chk(aux_sel, 5'h02);
    comp_en_pin <= 1'h0;
    repeat (4) @(posedge clk_sys);
    chk(ctrl_reset, 5'h01);
    chk(aux_sel, 5'h00);
    chk(tdo_oe_n, 5'h01);
    probe.bit_step(1'h0, 1'h0, t);
    probe.ir_load(tapsc_pkg::OP_CORE_DBG, cap);
    chk(aux_sel, 5'h00);
    chk(ctrl_reset, 5'h01);
    chk(aux_sel_nc, 5'h02);
    chk(ctrl_reset_nc, 5'h00);
    comp_en_pin <= 1'h1;
    repeat (4) @(posedge clk_sys);
  endtask : t_comp

  // ------------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    reset = 1'h1;
    comp_en_pin = 1'h1;
    aux_tdo = 5'h00;
    failures = 0;
    n_tests = 0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'h0;
    repeat (8) @(posedge clk_sys);
    t_reset();
    t_select();
    t_tms_reset();
    t_comp();
    conclude();
  end

  // the tests need about 1500 system cycles; allow over thirteen times that
  initial begin
    #(20000 * 25);
    failures++;
    conclude();
  end
endmodule : tb
